// File: hdl/qbsa_pkg.sv
// Constants, types and helper functions of the quad-bank SDRAM core.
package qbsa_pkg;

  localparam int ROW_W  = 12;
  localparam int COL_W  = 10;
  localparam int DQ_W   = 16;
  localparam int BANK_N = 4;
  localparam int APB_AW = 12;
  localparam int TMR_W  = 13;
  localparam int PCNT_W = 4;
  localparam int CFG_W  = 9;
  localparam int AP_BIT = 10;

  localparam int CLK_PS     = 4000;
  localparam int TRP_NS     = 20;
  localparam int TRFC_NS    = 66;
  localparam int REF_ROW_NS = 15600;
  localparam int TWR_CLK    = 2;
  localparam int TRP_CYC    = (TRP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TRFC_CYC   = (TRFC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int REF_CYC    = (REF_ROW_NS * 1000) / CLK_PS;
  localparam int LP_REF_CYC = 2 * REF_CYC;

  localparam logic [PCNT_W-1:0] TRP_LD  = PCNT_W'(TRP_CYC);
  localparam logic [PCNT_W-1:0] TWRP_LD = PCNT_W'(TRP_CYC + TWR_CLK);
  localparam logic [TMR_W-1:0]  TRFC_LD = TMR_W'(TRFC_CYC);
  localparam logic [TMR_W-1:0]  REF_LD  = TMR_W'(REF_CYC);

  localparam logic [APB_AW-1:0] CFG_OFS  = 12'h000;
  localparam logic [APB_AW-1:0] STAT_OFS = 12'h004;
  localparam logic [APB_AW-1:0] REFS_OFS = 12'h008;
  localparam logic [CFG_W-1:0]  CFG_RST  = 9'h053;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [1:0] WID_X4  = 2'h0;
  localparam logic [1:0] WID_X8  = 2'h1;

  typedef struct packed {
    logic       low_power;
    logic       automotive_grade;
    logic [1:0] width;
    logic       lat3;
    logic       interleave;
    logic [2:0] blen;
  } qbsa_cfg_t;

  typedef struct packed {
    logic             cke;
    logic             cs_n;
    logic [2:0]       rcw_n;
    logic [1:0]       bank;
    logic [ROW_W-1:0] addr;
  } qbsa_pins_t;

  typedef enum logic [2:0] {
    C_MRS = 3'h0, C_REF = 3'h1, C_PRE = 3'h2, C_ACT = 3'h3,
    C_WR  = 3'h4, C_RD  = 3'h5, C_BST = 3'h6, C_NOP = 3'h7
  } qbsa_cmd_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1, ST_AREF = 4'h2, ST_SELF = 4'h4, ST_PDN = 4'h8
  } qbsa_state_t;

  function automatic qbsa_cmd_t qbsa_decode(input qbsa_pins_t p);
    return p.cs_n ? C_NOP : qbsa_cmd_t'(p.rcw_n);
  endfunction : qbsa_decode

  function automatic logic [COL_W-1:0] qbsa_col_mask(input qbsa_cfg_t c);
    if (c.width == WID_X4) return 10'h3ff;
    if (c.width == WID_X8) return 10'h1ff;
    return 10'h0ff;
  endfunction : qbsa_col_mask

  function automatic logic [DQ_W-1:0] qbsa_dq_mask(input qbsa_cfg_t c);
    if (c.width == WID_X4) return 16'h000f;
    if (c.width == WID_X8) return 16'h00ff;
    return 16'hffff;
  endfunction : qbsa_dq_mask

  // Burst length minus one; also the column wrap mask of the burst.
  function automatic logic [COL_W-1:0] qbsa_wrap(input qbsa_cfg_t c);
    case (c.blen)
      BL_2:    return 10'h001;
      BL_4:    return 10'h003;
      BL_8:    return 10'h007;
      BL_FULL: return qbsa_col_mask(c);
      default: return 10'h000;
    endcase
  endfunction : qbsa_wrap

  function automatic logic [COL_W-1:0] qbsa_col_gen(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] cnt,
    input qbsa_cfg_t        c);
    logic [COL_W-1:0] w;
    logic [COL_W-1:0] s;
    w = qbsa_wrap(c);
    s = (c.interleave && c.blen != BL_FULL) ? (start ^ cnt) : (start + cnt);
    return (start & ~w) | (s & w);
  endfunction : qbsa_col_gen

endpackage : qbsa_pkg

// File: hdl/qbsa_sdram.sv
// Quad-bank SDRAM command core with APB configuration and status.
//
// Behaviour
// - Commands, address and data are taken only at the rising clock edge.
// - Burst length is one, two, four, eight or a full page.
// - Activate takes bank from two select pins, row from twelve address pins.
// - Read or write takes the start column, ten, nine or eight bits by width.
// - Later burst columns are made inside, sequential or interleaved.
// - Burst terminate ends a read or write burst, full page included.
// - Auto precharge closes the row by itself when the burst completes.
// - A new column address is accepted on every clock cycle.
// - One bank may precharge while another bank is accessed.
// - Self refresh runs on its own, standard or low-power variant.
// - Auto refresh by command and a power-down mode are provided.
// - Read latency is two or three clocks, chosen by the lat3 bit of the APB configuration register.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module qbsa_sdram
  import qbsa_pkg::*;
#(
  parameter int MEM_AW     = 12,
  parameter int SR_LP_CYC  = LP_REF_CYC
)(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             cke,
  input  wire logic             cs_n,
  input  wire logic             ras_n,
  input  wire logic             cas_n,
  input  wire logic             we_n,
  input  wire logic             bank_sel_lo,
  input  wire logic             bank_sel_hi,
  input  wire logic [ROW_W-1:0] row_col_addr_bus,
  input  wire logic [DQ_W-1:0]  dq_in,
  output logic      [DQ_W-1:0]  dq_out,
  output logic                  dq_oe
);

  localparam int CK = 8;
  localparam int RK = MEM_AW - 2 - CK;

  qbsa_pins_t        pins;
  qbsa_cmd_t         dec;
  qbsa_cmd_t         eff_cmd;
  logic              new_rw;
  qbsa_state_t       st_q, st_d;
  logic [TMR_W-1:0]  tmr_q, tmr_d, sr_ld;
  logic [ROW_W-1:0]  ref_row_q, ref_row_d;
  logic [31:0]       refs_q, refs_d;
  qbsa_cfg_t         cfg_q, cfg_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pslverr_q, pslverr_d;
  logic              bact_q, bact_d, bwr_q, bwr_d, bap_q, bap_d;
  logic [1:0]        bbank_q, bbank_d;
  logic [COL_W-1:0]  bcnt_q, bcnt_d, bstart_q, bstart_d;
  logic              acc_en, acc_go, acc_wr, ap_fire, ap_wr;
  logic [1:0]        acc_bank, ap_bank;
  logic [COL_W-1:0]  acc_col;
  logic [MEM_AW-1:0] acc_idx;
  logic [BANK_N-1:0] open_q, open_d;
  logic [ROW_W-1:0]  row_q [BANK_N];
  logic [ROW_W-1:0]  row_d [BANK_N];
  logic [PCNT_W-1:0] pcnt_q [BANK_N];
  logic [PCNT_W-1:0] pcnt_d [BANK_N];
  logic [DQ_W-1:0]   mem_q [2**MEM_AW];
  logic              rv0_q, rv0_d, rv1_q, rv1_d, oe_q, oe_d;
  logic [DQ_W-1:0]   rd0_q, rd0_d, rd1_q, rd1_d, dq_q, dq_d;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; nothing is accepted while refreshing or powered down.

  assign pins    = '{cke, cs_n, {ras_n, cas_n, we_n},
                     {bank_sel_hi, bank_sel_lo}, row_col_addr_bus};
  assign dec     = qbsa_decode(pins);
  assign eff_cmd = (st_q == ST_RUN && pins.cke) ? dec : C_NOP;
  assign new_rw  = (eff_cmd == C_RD) || (eff_cmd == C_WR);
  assign sr_ld   = cfg_q.low_power ? TMR_W'(SR_LP_CYC) : REF_LD;

  ////////////////////////////////////////////////////////////////////////////
  // Refresh and power state.

  always_comb
  begin
    st_d      = st_q;
    tmr_d     = tmr_q;
    ref_row_d = ref_row_q;
    refs_d    = refs_q;
    unique case (st_q)
      ST_RUN:
        if (dec == C_REF && pins.cke && !bact_q)
        begin
          st_d      = ST_AREF;
          tmr_d     = TRFC_LD;
          ref_row_d = ref_row_q + 12'h001;
          refs_d    = refs_q + 32'h0000_0001;
        end
        else if (dec == C_REF && !pins.cke && open_q == '0 &&
                 !cfg_q.automotive_grade)
        begin
          st_d  = ST_SELF;
          tmr_d = sr_ld;
        end
        else if (!pins.cke && dec == C_NOP && !bact_q)
          st_d = ST_PDN;
      ST_AREF:
      begin
        tmr_d = tmr_q - 13'h0001;
        if (tmr_q == 13'h0001)
          st_d = ST_RUN;
      end
      ST_SELF:
        if (pins.cke)
          st_d = ST_RUN;
        else if (tmr_q == 13'h0001)
        begin
          tmr_d     = sr_ld;
          ref_row_d = ref_row_q + 12'h001;
          refs_d    = refs_q + 32'h0000_0001;
        end
        else
          tmr_d = tmr_q - 13'h0001;
      ST_PDN:
        if (pins.cke)
          st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_q      <= ST_RUN;
      tmr_q     <= '0;
      ref_row_q <= '0;
      refs_q    <= '0;
    end
    else
    begin
      st_q      <= st_d;
      tmr_q     <= tmr_d;
      ref_row_q <= ref_row_d;
      refs_q    <= refs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst engine. A new read or write cuts short any burst in flight.

  always_comb
  begin
    bact_d   = bact_q;
    bwr_d    = bwr_q;
    bap_d    = bap_q;
    bbank_d  = bbank_q;
    bstart_d = bstart_q;
    bcnt_d   = bcnt_q;
    acc_en   = 1'b0;
    acc_wr   = bwr_q;
    acc_bank = bbank_q;
    acc_col  = qbsa_col_gen(bstart_q, bcnt_q, cfg_q);
    ap_fire  = 1'b0;
    ap_bank  = bbank_q;
    ap_wr    = bwr_q;
    if (new_rw)
    begin
      acc_en   = 1'b1;
      acc_wr   = (eff_cmd == C_WR);
      acc_bank = pins.bank;
      acc_col  = pins.addr[COL_W-1:0] & qbsa_col_mask(cfg_q);
      bact_d   = (qbsa_wrap(cfg_q) != '0);
      bwr_d    = acc_wr;
      bap_d    = pins.addr[AP_BIT];
      bbank_d  = pins.bank;
      bstart_d = acc_col;
      bcnt_d   = 10'h001;
      ap_fire  = !bact_d && bap_d;
      ap_bank  = pins.bank;
      ap_wr    = acc_wr;
    end
    else if (bact_q && eff_cmd == C_BST)
      bact_d = 1'b0;
    else if (bact_q)
    begin
      acc_en = 1'b1;
      bcnt_d = bcnt_q + 10'h001;
      // A full page wraps inside the row until terminated.
      if (cfg_q.blen != BL_FULL && bcnt_q == qbsa_wrap(cfg_q))
      begin
        bact_d  = 1'b0;
        ap_fire = bap_q;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bact_q   <= 1'b0;
      bwr_q    <= 1'b0;
      bap_q    <= 1'b0;
      bbank_q  <= '0;
      bstart_q <= '0;
      bcnt_q   <= '0;
    end
    else
    begin
      bact_q   <= bact_d;
      bwr_q    <= bwr_d;
      bap_q    <= bap_d;
      bbank_q  <= bbank_d;
      bstart_q <= bstart_d;
      bcnt_q   <= bcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank row state; each bank keeps its own precharge timer.

  always_comb
  begin
    for (int b = 0; b < BANK_N; b++)
    begin
      open_d[b] = open_q[b];
      row_d[b]  = row_q[b];
      pcnt_d[b] = (pcnt_q[b] != '0) ? pcnt_q[b] - 4'h1 : pcnt_q[b];
      if (eff_cmd == C_ACT && pins.bank == 2'(b) && pcnt_q[b] == '0)
      begin
        open_d[b] = 1'b1;
        row_d[b]  = pins.addr;
      end
      if (eff_cmd == C_PRE && open_q[b] &&
          (pins.addr[AP_BIT] || pins.bank == 2'(b)))
      begin
        open_d[b] = 1'b0;
        pcnt_d[b] = TRP_LD;
      end
      if (ap_fire && ap_bank == 2'(b))
      begin
        open_d[b] = 1'b0;
        pcnt_d[b] = ap_wr ? TWRP_LD : TRP_LD;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      open_q <= '0;
      row_q  <= '{default: '0};
      pcnt_q <= '{default: '0};
    end
    else
    begin
      open_q <= open_d;
      row_q  <= row_d;
      pcnt_q <= pcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage and read pipe. The bank and only the low row and column bits index the array,
  // so a small array aliases rows; that trades capacity for area.

  assign acc_go  = acc_en && open_q[acc_bank];
  assign acc_idx = {acc_bank, row_q[acc_bank][RK-1:0], acc_col[CK-1:0]};

  always_ff @(posedge clk_sys)
  begin
    if (acc_go && acc_wr)
      mem_q[acc_idx] <= dq_in & qbsa_dq_mask(cfg_q);
  end

  always_comb
  begin
    rv0_d = acc_go && !acc_wr;
    rd0_d = mem_q[acc_idx];
    rv1_d = rv0_q;
    rd1_d = rd0_q;
    oe_d  = cfg_q.lat3 ? rv1_q : rv0_q;
    dq_d  = cfg_q.lat3 ? rd1_q : rd0_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rv0_q <= 1'b0;
      rv1_q <= 1'b0;
      oe_q  <= 1'b0;
      rd0_q <= '0;
      rd1_q <= '0;
      dq_q  <= '0;
    end
    else
    begin
      rv0_q <= rv0_d;
      rv1_q <= rv1_d;
      oe_q  <= oe_d;
      rd0_q <= rd0_d;
      rd1_q <= rd1_d;
      dq_q  <= dq_d;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave. Read data is latched in the setup cycle, so pready needs
  // no wait state. Changing the setup during a burst is not guarded.

  always_comb
  begin
    cfg_d     = cfg_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (psel && !penable)
    begin
      pslverr_d = 1'b0;
      case (paddr)
        CFG_OFS:  prdata_d = 32'(cfg_q);
        STAT_OFS: prdata_d = {12'h000, ref_row_q, st_q == ST_AREF,
                              st_q == ST_SELF, st_q == ST_PDN, bact_q,
                              open_q};
        REFS_OFS: prdata_d = refs_q;
        default:
        begin
          prdata_d  = '0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && paddr == CFG_OFS)
      cfg_d = qbsa_cfg_t'(pwdata[CFG_W-1:0]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg_q     <= qbsa_cfg_t'(CFG_RST);
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign pready  = psel && penable;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_act_row_open: assert property (
    (eff_cmd == C_ACT && pcnt_q[pins.bank] == '0) |=>
      open_q[$past(pins.bank)] &&
      row_q[$past(pins.bank)] == $past(pins.addr))
    else $error("activate did not open the addressed row");

  a_start_col_taken: assert property (
    (new_rw && qbsa_wrap(cfg_q) != '0) |=> bact_q && bcnt_q == 10'h001 &&
      bstart_q == $past(pins.addr[COL_W-1:0] & qbsa_col_mask(cfg_q)))
    else $error("burst start column not captured");

  a_burst_four_len: assert property (
    (new_rw && cfg_q.blen == BL_4) ##1
      (!new_rw && eff_cmd != C_BST && $stable(cfg_q))[*3] |=> !bact_q)
    else $error("four-beat burst has wrong length");

  a_col_seq_walk: assert property (
    (bact_q && !new_rw && cfg_q.blen == BL_8 && !cfg_q.interleave) |->
      ((acc_col - bstart_q) & 10'h007) == (bcnt_q & 10'h007))
    else $error("sequential column order broken");

  a_bst_stops: assert property (
    (bact_q && eff_cmd == C_BST) |=> !bact_q && !rv0_q)
    else $error("burst terminate ignored");

  a_auto_pre_close: assert property (
    ap_fire |=> !open_q[$past(ap_bank)] &&
      pcnt_q[$past(ap_bank)] == ($past(ap_wr) ? TWRP_LD : TRP_LD))
    else $error("auto precharge did not start");

  a_read_each_cycle: assert property (
    (eff_cmd == C_RD && open_q[pins.bank]) |=> rv0_q)
    else $error("read command not taken");

  a_bank_parallel: assert property (
    (eff_cmd == C_ACT && pins.bank != 2'h0 && pcnt_q[pins.bank] == '0 &&
     pcnt_q[0] > 4'h1) |=>
      open_q[$past(pins.bank)] && pcnt_q[0] == $past(pcnt_q[0]) - 4'h1)
    else $error("bank activate blocked by other bank");

  a_lat_two: assert property (
    (eff_cmd == C_RD && open_q[pins.bank] && !cfg_q.lat3) ##1
      $stable(cfg_q) |-> ##1 dq_oe)
    else $error("latency two data missing");

  a_lat_three: assert property (
    (eff_cmd == C_RD && open_q[pins.bank] && cfg_q.lat3) ##1
      $stable(cfg_q)[*2] |=> dq_oe)
    else $error("latency three data missing");

  a_aref_enter: assert property (
    (st_q == ST_RUN && dec == C_REF && pins.cke && !bact_q) |=>
      st_q == ST_AREF && tmr_q == TRFC_LD)
    else $error("auto refresh not started");

  a_pdn_hold: assert property (
    (st_q == ST_PDN && !pins.cke) |=> st_q == ST_PDN && $stable(open_q))
    else $error("power-down left without clock enable");

  a_self_tick: assert property (
    (st_q == ST_SELF && !pins.cke && tmr_q == 13'h0001) |=>
      st_q == ST_SELF && ref_row_q == $past(ref_row_q) + 12'h001)
    else $error("self refresh row not advanced");

  a_no_self_auto: assert property (
    (st_q == ST_RUN && dec == C_REF && !pins.cke &&
     cfg_q.automotive_grade) |=> st_q != ST_SELF)
    else $error("automotive part entered self refresh");

  c_read_cl3: cover property (eff_cmd == C_RD && cfg_q.lat3 ##3 dq_oe);
  c_write_ap: cover property (ap_fire && ap_wr);
  c_self_ref: cover property (st_q == ST_SELF ##1 st_q == ST_RUN);
  c_burst_term: cover property (bact_q && eff_cmd == C_BST);

endmodule : qbsa_sdram

// File: testbench/qbsa_ctrl_model.sv
// Memory controller model that drives the SDRAM command and data pins.
`timescale 1ns/1ps
module qbsa_ctrl_model
  import qbsa_pkg::*;
(
  input  wire logic       clk_sys,
  output qbsa_pins_t      pins,
  output logic [DQ_W-1:0] dq_in
);
  logic [ROW_W:0] open_row [BANK_N];

  initial
  begin
    pins = '{cke: 1'b1, cs_n: 1'b1, rcw_n: 3'h7, bank: 2'h0, addr: '0};
    dq_in = 16'h0000;
    foreach (open_row[i]) open_row[i] = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command per call, changed after an edge and taken at the next.
  task automatic cmd(input qbsa_cmd_t        c,
                     input logic [1:0]       b,
                     input logic [ROW_W-1:0] a,
                     input logic             k,
                     input logic [DQ_W-1:0]  d);
    qbsa_cmd_t e;
    e = c;
    // An already open row needs no second activation.
    if (c == C_ACT && open_row[b] == {1'b1, a}) e = C_NOP;
    // No column access to a bank without an open row.
    if ((c == C_RD || c == C_WR) && !open_row[b][ROW_W]) e = C_NOP;
    if (e == C_ACT) open_row[b] = {1'b1, a};
    if ((e == C_RD || e == C_WR) && a[AP_BIT]) open_row[b] = '0;
    if (e == C_PRE && a[AP_BIT]) foreach (open_row[i]) open_row[i] = '0;
    if (e == C_PRE) open_row[b] = '0;
    pins <= '{cke: k, cs_n: 1'b0, rcw_n: 3'(e), bank: b, addr: a};
    dq_in <= d;
    @(posedge clk_sys);
  endtask : cmd

  // Idle cycles; the released data lines toggle so no stale value stands.
  task automatic nop(input int n, input logic k);
    for (int i = 0; i < n; i++)
    begin
      pins <= '{cke: k, cs_n: 1'b1, rcw_n: 3'h7, bank: 2'h0, addr: '0};
      dq_in <= ~dq_in;
      @(posedge clk_sys);
    end
  endtask : nop
endmodule : qbsa_ctrl_model

// File: testbench/quad_bank_sdram_access_test.sv
// Self-checking bench of the quad-bank SDRAM core.
`timescale 1ns/1ps
module quad_bank_sdram_access_test
  import qbsa_pkg::*;
;
  typedef struct packed {logic [15:0] d; logic [31:0] t;} qbsa_exp_t;
  localparam logic [31:0] F = 32'hffff_ffff;
  localparam logic [31:0] Z = 32'h0000_0000;

  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic        dq_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cyc, seed;
  logic [15:0] dq_in, dq_out;
  qbsa_pins_t  pins;
  qbsa_exp_t   expq[$];
  logic [15:0] mem[int];
  logic [9:0]  rc[4] = '{10'h006, 10'h001, 10'h003, 10'h004};
  int          fail_count, n_checks;

  qbsa_ctrl_model ctrl (.clk_sys(clk_sys), .pins(pins), .dq_in(dq_in));

  qbsa_sdram #(.MEM_AW(12), .SR_LP_CYC(20)) DUT (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cke(pins.cke),
    .cs_n(pins.cs_n), .ras_n(pins.rcw_n[2]), .cas_n(pins.rcw_n[1]),
    .we_n(pins.rcw_n[0]), .bank_sel_lo(pins.bank[0]),
    .bank_sel_hi(pins.bank[1]), .row_col_addr_bus(pins.addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] r16();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : r16

  function automatic logic [9:0] col(input logic [9:0] s, input int i,
                                     input logic [9:0] m, input logic v);
    return v ? s ^ 10'(i) : (s & ~m) | ((s + 10'(i)) & m);
  endfunction : col

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_reg

  // Data and sampling edge are compared together, so latency counts too.
  task automatic check_beat(input qbsa_exp_t e);
    n_checks++;
    if ({dq_out, cyc} !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time,
               {dq_out, cyc}, e);
    end
  endtask : check_beat

  always @(posedge clk_sys)
  begin
    if (dq_oe === 1'b1)
      check_beat(expq.size() == 0 ? '0 : expq.pop_front());
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, input logic [31:0] ex,
                     input logic [31:0] mk, input logic ee);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 8) fail_count++;
    if (i == 8) close_out();
    if (!w) check_reg(prdata & mk, ex);
    check_reg({31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic go(input qbsa_cmd_t c, input logic [1:0] b,
                    input logic [11:0] a);
    ctrl.cmd(c, b, a, 1'b1, r16());
  endtask : go

  task automatic wrb(input logic [1:0] b, input logic [11:0] a,
                     input int n, input logic [9:0] m, input logic v);
    logic [9:0]  c;
    logic [15:0] d;
    for (int i = 0; i < n; i++)
    begin
      c = col(a[9:0], i, m, v);
      d = r16();
      mem[{b, c}] = d;
      ctrl.cmd(i == 0 ? C_WR : C_NOP, b, a, 1'b1, d);
    end
  endtask : wrb

  task automatic rdb(input logic [1:0] b, input logic [11:0] a, input int n,
                     input logic [9:0] m, input int cl, input logic v);
    for (int i = 0; i < n; i++)
      expq.push_back('{d: mem[{b, col(a[9:0], i, m, v)}],
                       t: cyc + 32'(cl + 1 + i)});
    go(C_RD, b, a);
  endtask : rdb

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc = Z;
    seed = 32'h0000_8585;
    fail_count = 0;
    n_checks = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = Z;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, CFG_OFS, Z, 32'h0000_0053, F, 1'b0);
    apb(1'b0, 12'h00c, Z, Z, F, 1'b1);
    apb(1'b1, STAT_OFS, F, Z, Z, 1'b0);
    apb(1'b0, STAT_OFS, Z, Z, F, 1'b0);
    // Burst of four, sequential then interleaved, latency three, wide part.
    apb(1'b1, CFG_OFS, 32'h0000_0052, Z, Z, 1'b0);
    apb(1'b0, CFG_OFS, Z, 32'h0000_0052, F, 1'b0);
    go(C_ACT, 2'h0, 12'h000);
    wrb(2'h0, 12'h000, 4, 10'h003, 1'b0);
    wrb(2'h0, 12'h004, 4, 10'h003, 1'b0);
    rdb(2'h0, 12'h006, 4, 10'h003, 3, 1'b0);
    ctrl.nop(8, 1'b1);
    foreach (rc[k])
      rdb(2'h0, {2'h0, rc[k]}, k == 3 ? 4 : 1, 10'h003, 3, 1'b0);
    ctrl.nop(8, 1'b1);
    apb(1'b1, CFG_OFS, 32'h0000_005a, Z, Z, 1'b0);
    rdb(2'h0, 12'h001, 4, 10'h003, 3, 1'b1);
    ctrl.nop(8, 1'b1);
    // Full page at latency two, cut after three beats.
    apb(1'b1, CFG_OFS, 32'h0000_0047, Z, Z, 1'b0);
    rdb(2'h0, 12'h001, 3, 10'h0ff, 2, 1'b0);
    ctrl.nop(2, 1'b1);
    go(C_BST, 2'h0, 12'h000);
    ctrl.nop(8, 1'b1);
    // Single beats; bank zero closes by itself while others work.
    apb(1'b1, CFG_OFS, 32'h0000_0050, Z, Z, 1'b0);
    go(C_ACT, 2'h1, 12'h000);
    wrb(2'h0, 12'h408, 1, 10'h000, 1'b0);
    go(C_ACT, 2'h2, 12'h000);
    wrb(2'h1, 12'h000, 1, 10'h000, 1'b0);
    rdb(2'h1, 12'h000, 1, 10'h000, 3, 1'b0);
    ctrl.nop(12, 1'b1);
    apb(1'b0, STAT_OFS, Z, 32'h0000_0006, 32'h0000_00ff, 1'b0);
    go(C_ACT, 2'h0, 12'h000);
    rdb(2'h0, 12'h008, 1, 10'h000, 3, 1'b0);
    ctrl.nop(6, 1'b1);
    go(C_PRE, 2'h0, 12'h400);
    ctrl.nop(6, 1'b1);
    go(C_REF, 2'h0, 12'h000);
    ctrl.nop(20, 1'b1);
    apb(1'b0, REFS_OFS, Z, 32'h0000_0001, F, 1'b0);
    apb(1'b0, STAT_OFS, Z, Z, 32'h0000_0080, 1'b0);
    // Self refresh only on a part that is not automotive grade.
    apb(1'b1, CFG_OFS, 32'h0000_0150, Z, Z, 1'b0);
    ctrl.cmd(C_REF, 2'h0, 12'h000, 1'b0, r16());
    ctrl.nop(1, 1'b0);
    apb(1'b0, STAT_OFS, Z, 32'h0000_0040, 32'h0000_0040, 1'b0);
    ctrl.nop(60, 1'b0);
    ctrl.nop(4, 1'b1);
    apb(1'b0, STAT_OFS, Z, Z, 32'h0000_0040, 1'b0);
    ctrl.nop(2, 1'b0);
    apb(1'b0, STAT_OFS, Z, 32'h0000_0020, 32'h0000_0020, 1'b0);
    ctrl.nop(3, 1'b1);
    apb(1'b0, STAT_OFS, Z, Z, 32'h0000_0020, 1'b0);
    // Eight-beat sequential read at latency two wraps inside its block.
    apb(1'b1, CFG_OFS, 32'h0000_0043, Z, Z, 1'b0);
    go(C_ACT, 2'h0, 12'h000);
    rdb(2'h0, 12'h005, 8, 10'h007, 2, 1'b0);
    ctrl.nop(10, 1'b1);
    go(C_PRE, 2'h0, 12'h400);
    // An automotive part stays awake and is refreshed by command.
    apb(1'b1, CFG_OFS, 32'h0000_00d0, Z, Z, 1'b0);
    ctrl.cmd(C_REF, 2'h0, 12'h000, 1'b0, r16());
    apb(1'b0, STAT_OFS, Z, Z, 32'h0000_0060, 1'b0);
    go(C_REF, 2'h0, 12'h000);
    apb(1'b0, STAT_OFS, Z, 32'h0000_0080, 32'h0000_00c0, 1'b0);
    check_reg(32'(expq.size()), Z);
    close_out();
  end
endmodule : quad_bank_sdram_access_test
